// [adccd_top.sv]
// converter back end: offset/gain correction, sample dma, analog routing and pin mode
// assumes raw samples and ram handshake are synchronous to i_core_clk
//
// Overview of operation
// - pin with config field zero is analog; its input reads back as one.
// - raw sample plus signed offset register on each completed conversion.
// - gain product clamps to 0x7FFF or 0x8000 and sets saturation flag.
// - gain is unsigned, bit 15 integer, bits 14..0 fraction.
// - reset gives offset zero and gain 0x8000 for unity.
// - dma stores corrected samples only, never the raw value.
// - buffer count register counts 16-bit samples.
// - reset the channel, then set load to start transfers.
// - wrap select zero gives linear mode, one gives auto-wrap.
// - linear mode stops after count samples and sets full flag.
// - sample after linear buffer full sets overflow flag.
// - auto-wrap reloads pointer with start at buffer end.
// - auto-wrap runs until converter disabled or channel reset.
// - half flag after lower half filled, full flag after upper half.
// - current pointer register reads the next address to be written, or the last one written once a linear buffer is full.
// - two 4-bit source selects; 0-5 external, 8-11 internal, others open.
// - selected input buffer scales input by 0.25.
// - positive and negative buffers have separate enable bits.
// - config changes other than converter disable or channel reset do not stop a running dma.
`timescale 1ns/1ps
module adccd_top
	import adccd_pkg::*;
(
	input  wire logic                      i_core_clk,
	input  wire logic                      i_rst_b,
	input  wire logic [31:0]               i_awaddr,
	input  wire logic                      i_awvalid,
	output logic                           o_awready,
	input  wire logic [31:0]               i_wdata,
	input  wire logic [3:0]                i_wstrb,
	input  wire logic                      i_wvalid,
	output logic                           o_wready,
	output logic [1:0]                     o_bresp,
	output logic                           o_bvalid,
	input  wire logic                      i_bready,
	input  wire logic [31:0]               i_araddr,
	input  wire logic                      i_arvalid,
	output logic                           o_arready,
	output logic [31:0]                    o_rdata,
	output logic [1:0]                     o_rresp,
	output logic                           o_rvalid,
	input  wire logic                      i_rready,
	input  wire logic                      i_raw_valid,
	input  wire logic [15:0]               i_raw_data,
	output adccd_pkg::adccd_conv_t         o_conv,
	output logic                           o_pos_connected,
	output logic                           o_neg_connected,
	input  wire logic [PIN_FIELDS-1:0]     i_pin_in,
	output logic [PIN_FIELDS-1:0]          o_pin_analog,
	output adccd_pkg::adccd_ram_wr_t       o_ram_wr,
	output logic                           o_ram_valid,
	input  wire logic                      i_ram_ready
);
	import adccd_pkg::*;

	logic [31:0]      conv_cfg;
	logic [15:0]      offset;
	logic [15:0]      gain;
	logic [31:0]      buf_start;
	logic [15:0]      buf_count;
	logic             wrap_select;
	logic [FLAG_W-1:0] flags;
	logic [31:0]      pin_cfg;
	adccd_dma_state_t dma_state;
	logic [31:0]      cur_ptr;
	logic [15:0]      sample_idx;
	logic [15:0]      sample;
	logic             sample_valid;
	logic [31:0]      aw_addr;
	logic             aw_full;
	logic [31:0]      w_data;
	logic [3:0]       w_strb;
	logic             w_full;
	logic             wr_fire;
	logic             wr_hit;
	logic             rd_hit;
	logic [31:0]      rd_word;
	logic [31:0]      wr_word;
	logic             load_pulse;
	logic             rst_pulse;
	logic [FLAG_W-1:0] flag_clear;
	logic [FLAG_W-1:0] flag_set;
	logic             ram_fire;
	logic             last_sample;
	logic             half_sample;
	logic [PIN_FIELDS-1:0] pin_view;
	logic [16:0]      next_sum;
	logic [33:0]      next_prod;
	logic [33:0]      next_shift;
	logic             next_sat;
	logic [15:0]      next_sample;

	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic src_connected(input logic [3:0] code);
		return (code <= SRC_EXT_LAST) || ((code >= SRC_GND) && (code <= SRC_HALF_REG));
	endfunction

	// write channel capture, either order
	assign o_awready = !aw_full && !o_bvalid;
	assign o_wready  = !w_full && !o_bvalid;
	assign wr_fire   = aw_full && w_full && !o_bvalid;

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			aw_full <= 1'b0;
			aw_addr <= 32'h00000000;
		end else if (i_awvalid && o_awready) begin
			aw_full <= 1'b1;
			aw_addr <= i_awaddr;
		end else if (wr_fire) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			w_full <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (i_wvalid && o_wready) begin
			w_full <= 1'b1;
			w_data <= i_wdata;
			w_strb <= i_wstrb;
		end else if (wr_fire) begin
			w_full <= 1'b0;
		end
	end

	always_comb begin
		unique case (aw_addr[7:0])
			ADDR_CONV_CFG, ADDR_OFFSET, ADDR_GAIN, ADDR_BUF_START, ADDR_BUF_COUNT,
			ADDR_DMA_CFG, ADDR_FLAGS, ADDR_PIN_CFG: wr_hit = (aw_addr[31:8] == 24'h000000);
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bvalid <= 1'b0;
			o_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			o_bvalid <= 1'b1;
			o_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// register writes
	assign wr_word    = merge_strb(32'h00000000, w_data, w_strb);
	assign load_pulse = wr_fire && wr_hit && (aw_addr[7:0] == ADDR_DMA_CFG) && wr_word[DMA_LOAD_BIT];
	assign rst_pulse  = wr_fire && wr_hit && (aw_addr[7:0] == ADDR_DMA_CFG) && wr_word[DMA_RST_BIT];
	assign flag_clear = (wr_fire && wr_hit && (aw_addr[7:0] == ADDR_FLAGS)) ? wr_word[FLAG_W-1:0]
		: {FLAG_W{1'b0}};

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			conv_cfg    <= CONV_CFG_RESET;
			offset      <= OFFSET_RESET;
			gain        <= GAIN_RESET;
			buf_start   <= START_RESET;
			buf_count   <= COUNT_RESET;
			wrap_select <= 1'b0;
			pin_cfg     <= PIN_CFG_RESET;
		end else if (wr_fire && wr_hit) begin
			unique case (aw_addr[7:0])
				ADDR_CONV_CFG:  conv_cfg  <= merge_strb(conv_cfg, w_data, w_strb) & CONV_CFG_MASK;
				ADDR_OFFSET:    offset    <= 16'(merge_strb({16'h0000, offset}, w_data,
					w_strb));
				ADDR_GAIN:      gain      <= 16'(merge_strb({16'h0000, gain}, w_data, w_strb));
				ADDR_BUF_START: buf_start <= merge_strb(buf_start, w_data, w_strb);
				ADDR_BUF_COUNT: buf_count <= 16'(merge_strb({16'h0000, buf_count}, w_data,
					w_strb));
				ADDR_DMA_CFG:   wrap_select <= w_strb[0] ? w_data[DMA_WRAP_BIT]
					: wrap_select;
				ADDR_PIN_CFG:   pin_cfg   <= merge_strb(pin_cfg, w_data, w_strb);
				default: begin
				end
			endcase
		end
	end

	// analog pin mode
	generate
		for (genvar p = 0; p < PIN_FIELDS; p++) begin : g_pin
			assign o_pin_analog[p] = (pin_cfg[p*4 +: 4] == PIN_ANALOG_CODE);
			assign pin_view[p]     = o_pin_analog[p] ? 1'b1 : i_pin_in[p];
		end
	endgenerate

	// source and buffer routing to the analog front end
	assign o_conv.enable    = conv_cfg[CONV_EN_BIT];
	assign o_conv.pos_src   = conv_cfg[POS_SRC_LSB +: 4];
	assign o_conv.neg_src   = conv_cfg[NEG_SRC_LSB +: 4];
	assign o_conv.pos_buf   = conv_cfg[POS_BUF_BIT];
	assign o_conv.neg_buf   = conv_cfg[NEG_BUF_BIT];
	assign o_pos_connected  = src_connected(o_conv.pos_src);
	assign o_neg_connected  = src_connected(o_conv.neg_src);

	// read channel
	always_comb begin
		rd_hit  = (i_araddr[31:8] == 24'h000000);
		rd_word = 32'h00000000;
		unique case (i_araddr[7:0])
			ADDR_CONV_CFG:  rd_word = conv_cfg;
			ADDR_OFFSET:    rd_word = {16'h0000, offset};
			ADDR_GAIN:      rd_word = {16'h0000, gain};
			ADDR_BUF_START: rd_word = buf_start;
			ADDR_BUF_COUNT: rd_word = {16'h0000, buf_count};
			ADDR_DMA_CFG:   rd_word = {30'h00000000, wrap_select, 1'b0};
			ADDR_DMA_CUR:   rd_word = cur_ptr;
			ADDR_FLAGS:     rd_word = {28'h0000000, flags};
			ADDR_PIN_CFG:   rd_word = pin_cfg;
			ADDR_PIN_IN:    rd_word = {24'h000000, pin_view};
			default:        rd_hit  = 1'b0;
		endcase
	end

	assign o_arready = !o_rvalid;

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h00000000;
			o_rresp  <= RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rdata  <= rd_hit ? rd_word : 32'h00000000;
			o_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end

	// offset and gain correction
	always_comb begin
		next_sum    = 17'({i_raw_data[15], i_raw_data} + {offset[15], offset});
		next_prod   = 34'($signed(next_sum) * $signed({1'b0, gain}));
		next_shift  = 34'($signed(next_prod) >>> GAIN_FRAC_BITS);
		next_sat    = (next_shift[33:15] != {19{next_shift[15]}});
		next_sample = next_sat ? (next_shift[33] ? SAT_MIN : SAT_MAX) : next_shift[15:0];
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sample       <= 16'h0000;
			sample_valid <= 1'b0;
		end else begin
			sample_valid <= i_raw_valid;
			if (i_raw_valid) begin
				sample <= next_sample;
			end
		end
	end

	// dma channel
	assign ram_fire    = o_ram_valid && i_ram_ready;
	assign last_sample = (16'(sample_idx + 16'h0001) == buf_count);
	assign half_sample = (16'(sample_idx + 16'h0001) == (buf_count >> 1));

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dma_state  <= DMA_IDLE;
			cur_ptr    <= START_RESET;
			sample_idx <= 16'h0000;
		end else if (!o_conv.enable || rst_pulse) begin
			dma_state  <= DMA_IDLE;
			cur_ptr    <= buf_start;
			sample_idx <= 16'h0000;
		end else if (load_pulse && (dma_state == DMA_IDLE)) begin
			dma_state  <= DMA_RUN;
			cur_ptr    <= buf_start;
			sample_idx <= 16'h0000;
		end else if (ram_fire && (dma_state == DMA_RUN)) begin
			if (last_sample && !wrap_select) begin
				dma_state  <= DMA_FULL;
			end else if (last_sample) begin
				cur_ptr    <= buf_start;
				sample_idx <= 16'h0000;
			end else begin
				cur_ptr    <= cur_ptr + SAMPLE_STEP;
				sample_idx <= 16'(sample_idx + 16'h0001);
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ram_valid <= 1'b0;
			o_ram_wr    <= '0;
		end else if (o_ram_valid) begin
			if (i_ram_ready) begin
				o_ram_valid <= 1'b0;
			end
		end else if (sample_valid && (dma_state == DMA_RUN) && o_conv.enable && !rst_pulse) begin
			o_ram_valid   <= 1'b1;
			o_ram_wr.addr <= cur_ptr;
			o_ram_wr.data <= sample;
		end
	end

	// sticky flags, set wins over clear
	always_comb begin
		flag_set            = {FLAG_W{1'b0}};
		flag_set[FLAG_SAT]  = i_raw_valid && next_sat;
		flag_set[FLAG_HALF] = ram_fire && (dma_state == DMA_RUN) && half_sample;
		flag_set[FLAG_FULL] = ram_fire && (dma_state == DMA_RUN) && last_sample;
		flag_set[FLAG_OVF]  = sample_valid && (dma_state == DMA_FULL) && o_conv.enable
			&& !rst_pulse;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			flags <= {FLAG_W{1'b0}};
		end else begin
			flags <= (flags & ~flag_clear) | flag_set;
		end
	end

	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	sat_flag_set_a: assert property (i_raw_valid && next_sat |=> flags[FLAG_SAT]
		&& (sample == SAT_MAX || sample == SAT_MIN))
		else $error("saturation not flagged or not clamped");
	unity_path_a: assert property (i_raw_valid && gain == GAIN_RESET && offset == OFFSET_RESET
		|=> sample == $past(i_raw_data))
		else $error("unity correction altered the sample");
	offset_add_a: assert property (i_raw_valid && gain == GAIN_RESET && !next_sat
		|=> sample == 16'($past(i_raw_data) + $past(offset)))
		else $error("offset not added before unity gain");
	dma_corrected_a: assert property (sample_valid && dma_state == DMA_RUN && !o_ram_valid
		&& o_conv.enable && !rst_pulse |=> o_ram_valid && o_ram_wr.data == $past(sample))
		else $error("dma did not store the corrected sample");
	load_starts_a: assert property (load_pulse && o_conv.enable && dma_state == DMA_IDLE
		&& !rst_pulse |=> dma_state == DMA_RUN && cur_ptr == $past(buf_start))
		else $error("load did not start the channel");
	linear_stop_a: assert property (ram_fire && dma_state == DMA_RUN && last_sample
		&& !wrap_select && o_conv.enable && !rst_pulse |=> dma_state == DMA_FULL
		&& flags[FLAG_FULL])
		else $error("linear buffer did not stop full");
	overflow_flag_a: assert property (dma_state == DMA_FULL && sample_valid && o_conv.enable
		&& !rst_pulse |=> flags[FLAG_OVF])
		else $error("overflow not flagged");
	wrap_reload_a: assert property (ram_fire && dma_state == DMA_RUN && last_sample
		&& wrap_select && o_conv.enable && !rst_pulse |=> cur_ptr == $past(buf_start)
		&& dma_state == DMA_RUN)
		else $error("wrap did not reload pointer");
	disable_stops_a: assert property (!o_conv.enable |=> dma_state == DMA_IDLE)
		else $error("channel kept running while disabled");
	half_flag_a: assert property (ram_fire && dma_state == DMA_RUN && half_sample |=>
		flags[FLAG_HALF])
		else $error("half flag missed");
	pin_reads_one_a: assert property (o_pin_analog[0] && i_arvalid && o_arready
		&& i_araddr == {24'h000000, ADDR_PIN_IN} |=> o_rdata[0])
		else $error("analog pin did not read as one");

	wrap_seen_c: cover property (ram_fire && wrap_select && last_sample);
	overflow_seen_c: cover property (flag_set[FLAG_OVF]);
	sat_seen_c: cover property (flag_set[FLAG_SAT]);
	half_then_full_c: cover property (flag_set[FLAG_HALF] ##[1:200] flag_set[FLAG_FULL]);
endmodule

// [adccd_pkg.sv]
// constants, types and register map of the converter correction and dma block
// assumes a single clock domain and an axi4-lite master for software access
package adccd_pkg;
	// register byte offsets
	localparam logic [7:0]  ADDR_CONV_CFG   = 8'h00;
	localparam logic [7:0]  ADDR_OFFSET     = 8'h04;
	localparam logic [7:0]  ADDR_GAIN       = 8'h08;
	localparam logic [7:0]  ADDR_BUF_START  = 8'h0C;
	localparam logic [7:0]  ADDR_BUF_COUNT  = 8'h10;
	localparam logic [7:0]  ADDR_DMA_CFG    = 8'h14;
	localparam logic [7:0]  ADDR_DMA_CUR    = 8'h18;
	localparam logic [7:0]  ADDR_FLAGS      = 8'h1C;
	localparam logic [7:0]  ADDR_PIN_CFG    = 8'h20;
	localparam logic [7:0]  ADDR_PIN_IN     = 8'h24;
	// converter configuration fields
	localparam int          CONV_EN_BIT     = 0;
	localparam int          POS_SRC_LSB     = 4;
	localparam int          NEG_SRC_LSB     = 8;
	localparam int          POS_BUF_BIT     = 12;
	localparam int          NEG_BUF_BIT     = 13;
	localparam logic [31:0] CONV_CFG_MASK   = 32'h00003FF1;
	localparam logic [31:0] CONV_CFG_RESET  = 32'h00000000;
	// correction registers
	localparam logic [15:0] OFFSET_RESET    = 16'h0000;
	localparam logic [15:0] GAIN_RESET      = 16'h8000;
	localparam int          GAIN_FRAC_BITS  = 15;
	localparam logic [15:0] SAT_MAX         = 16'h7FFF;
	localparam logic [15:0] SAT_MIN         = 16'h8000;
	// dma configuration fields
	localparam int          DMA_LOAD_BIT    = 0;
	localparam int          DMA_WRAP_BIT    = 1;
	localparam int          DMA_RST_BIT     = 4;
	localparam logic [31:0] START_RESET     = 32'h00000000;
	localparam logic [15:0] COUNT_RESET     = 16'h0000;
	// flag positions
	localparam int          FLAG_HALF       = 0;
	localparam int          FLAG_FULL       = 1;
	localparam int          FLAG_OVF        = 2;
	localparam int          FLAG_SAT        = 3;
	localparam int          FLAG_W          = 4;
	// source select codes
	localparam logic [3:0]  SRC_EXT_LAST    = 4'h5;
	localparam logic [3:0]  SRC_GND         = 4'h8;
	localparam logic [3:0]  SRC_HALF_REG    = 4'hB;
	// pins
	localparam int          PIN_FIELDS      = 8;
	localparam logic [3:0]  PIN_ANALOG_CODE = 4'h0;
	localparam logic [31:0] PIN_CFG_RESET   = 32'h11111111;
	// bus answers and dma sample step
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
	localparam logic [31:0] SAMPLE_STEP     = 32'h00000002;

	typedef enum logic [1:0] {
		DMA_IDLE,
		DMA_RUN,
		DMA_FULL
	} adccd_dma_state_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] data;
	} adccd_ram_wr_t;

	typedef struct packed {
		logic       neg_buf;
		logic       pos_buf;
		logic [3:0] neg_src;
		logic [3:0] pos_src;
		logic       enable;
	} adccd_conv_t;
endpackage

// [adccd_ram_model.sv]
// behavioural system ram taking the dma sample writes, stalling at random
// assumes adccd_pkg is compiled first and a single clock domain
`timescale 1ns/1ps
module adccd_ram_model
	import adccd_pkg::*;
(
	input  wire logic                      i_core_clk,
	input  wire logic                      i_rst_b,
	input  wire adccd_pkg::adccd_ram_wr_t  i_ram_wr,
	input  wire logic                      i_ram_valid,
	output logic                           o_ram_ready,
	output adccd_pkg::adccd_ram_wr_t       o_last,
	output int                             o_wr_cnt
);
	// ready toggles freely, a write lands only on valid and ready
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ram_ready <= 1'b0;
			o_wr_cnt    <= 0;
			o_last      <= '0;
		end else begin
			o_ram_ready <= ($urandom_range(0, 2) != 0);
			if (i_ram_valid && o_ram_ready) begin
				o_last   <= i_ram_wr;
				o_wr_cnt <= o_wr_cnt + 1;
			end
		end
	end
endmodule

// [tb_top.sv]
// self-checking bench for adccd_top with a behavioural ram on the dma side
// assumes adccd_pkg, adccd_ram_model and adccd_top are compiled before it
`timescale 1ns/1ps
module tb_top;
	import adccd_pkg::*;
	logic          clk       = 1'b0;
	logic          rst_b     = 1'b0;
	logic [31:0]   awaddr    = '0;
	logic [31:0]   wdata     = '0;
	logic [31:0]   araddr    = '0;
	logic          awvalid   = 1'b0;
	logic          wvalid    = 1'b0;
	logic          bready    = 1'b0;
	logic          arvalid   = 1'b0;
	logic          rready    = 1'b0;
	logic          raw_valid = 1'b0;
	logic [15:0]   raw_data  = '0;
	logic [7:0]    pin_in    = '0;
	logic          awready, wready, bvalid, arready, rvalid;
	logic          pos_con, neg_con, ram_valid, ram_ready;
	logic [1:0]    bresp, rresp;
	logic [31:0]   rdata;
	logic [7:0]    pin_analog;
	adccd_conv_t   conv;
	adccd_ram_wr_t ram_wr, last;
	int            wr_cnt;
	int            error_cnt = 0;
	int            checks    = 0;

	always #2.5 clk = ~clk;

	adccd_top adccd_top_inst (
		.i_core_clk(clk), .i_rst_b(rst_b), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_raw_valid(raw_valid),
		.i_raw_data(raw_data), .o_conv(conv), .o_pos_connected(pos_con), .o_neg_connected(neg_con),
		.i_pin_in(pin_in), .o_pin_analog(pin_analog), .o_ram_wr(ram_wr), .o_ram_valid(ram_valid),
		.i_ram_ready(ram_ready)
	);

	adccd_ram_model adccd_ram_model_inst (
		.i_core_clk(clk), .i_rst_b(rst_b), .i_ram_wr(ram_wr), .i_ram_valid(ram_valid),
		.o_ram_ready(ram_ready), .o_last(last), .o_wr_cnt(wr_cnt)
	);

	task automatic results();
		if (error_cnt == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr  <= {24'h0, a};
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr  <= {24'h0, a};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d & m, e);
	endtask

	// one conversion pulse, then a bounded wait for the ram write
	task automatic smp(input logic [15:0] raw, input int exp_wr);
		int n0;
		n0 = wr_cnt;
		raw_valid <= 1'b1;
		raw_data  <= raw;
		@(posedge clk);
		raw_valid <= 1'b0;
		for (int k = 0; k < 40 && wr_cnt == n0; k++) @(posedge clk);
		chk(wr_cnt - n0, exp_wr);
	endtask

	// offset add, unsigned q1.15 gain, floor shift, clamp; bit 16 is saturation
	function automatic logic [16:0] corr(input logic [15:0] raw, input logic [15:0] off, input logic [15:0] gain);
		logic signed [16:0] s;
		logic signed [33:0] p;
		s = $signed({raw[15], raw}) + $signed({off[15], off});
		p = (s * $signed({1'b0, gain})) >>> 15;
		if (p > 34'sh7FFF) return {1'b1, 16'h7FFF};
		if (p < -34'sh8000) return {1'b1, 16'h8000};
		return {1'b0, p[15:0]};
	endfunction

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		results();
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [15:0] raw, off, gain;
		logic [16:0] e;
		logic        sat;
		logic        c;
		void'($urandom(32'h56C6D7E7));
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rchk(ADDR_OFFSET, 32'hFFFFFFFF, 32'h0);
		rchk(ADDR_GAIN, 32'hFFFFFFFF, 32'h8000);
		rd(8'h40, d, r);
		chk(r, RESP_SLVERR);
		wr(8'h40, 32'h0);
		chk(bresp, RESP_SLVERR);
		pin_in <= 8'($urandom);
		wr(ADDR_PIN_CFG, 32'h11111110);
		chk(pin_analog, 8'h01);
		rchk(ADDR_PIN_IN, 32'hFF, {24'h0, pin_in[7:1], 1'b1});
		for (int k = 0; k < 16; k++) begin
			wr(ADDR_CONV_CFG, {18'h0, ~k[0], k[0], k[3:0], k[3:0], 4'h1});
			c = (k <= 5) || (k >= 8 && k <= 11);
			chk({pos_con, neg_con}, {c, c});
			chk({conv.pos_src, conv.neg_src, conv.enable}, {k[3:0], k[3:0], 1'b1});
			chk({conv.pos_buf, conv.neg_buf}, {k[0], ~k[0]});
		end
		wr(ADDR_CONV_CFG, 32'h00000901);
		wr(ADDR_DMA_CFG, 32'h10);
		wr(ADDR_BUF_START, 32'h100);
		wr(ADDR_BUF_COUNT, 32'h4);
		wr(ADDR_FLAGS, 32'hF);
		wr(ADDR_DMA_CFG, 32'h1);
		sat = 1'b0;
		for (int i = 0; i < 4; i++) begin
			raw  = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 : 16'($urandom);
			off  = (i == 0) ? 16'h0100 : (i == 1) ? 16'hFF00 : (i == 2) ? OFFSET_RESET : 16'($urandom);
			gain = (i < 2) ? 16'hFFFF : (i == 2) ? GAIN_RESET : 16'($urandom);
			wr(ADDR_OFFSET, {16'h0, off});
			wr(ADDR_GAIN, {16'h0, gain});
			e = corr(raw, off, gain);
			sat |= e[16];
			smp(raw, 1);
			chk(last.addr, 32'h100 + 2 * i);
			chk(last.data, e[15:0]);
			if (i < 3) rchk(ADDR_DMA_CUR, 32'hFFFFFFFF, 32'h100 + 2 * (i + 1));
			if (i == 1) rchk(ADDR_FLAGS, 32'h3, 32'h1);
		end
		rchk(ADDR_FLAGS, 32'hF, {28'h0, sat, 3'b011});
		smp(16'h1234, 0);
		rchk(ADDR_FLAGS, 32'h4, 32'h4);
		wr(ADDR_DMA_CFG, 32'h10);
		wr(ADDR_BUF_START, 32'h200);
		wr(ADDR_BUF_COUNT, 32'h2);
		wr(ADDR_FLAGS, 32'hF);
		wr(ADDR_DMA_CFG, 32'h3);
		for (int i = 0; i < 3; i++) begin
			if (i == 1) wr(ADDR_CONV_CFG, 32'h00000911);
			raw = 16'($urandom);
			e = corr(raw, off, gain);
			smp(raw, 1);
			chk(last.addr, 32'h200 + 2 * (i % 2));
			chk(last.data, e[15:0]);
		end
		rchk(ADDR_FLAGS, 32'h7, 32'h3);
		wr(ADDR_CONV_CFG, 32'h00000900);
		smp(16'h0042, 0);
		results();
	end
endmodule
